// ---- isc_top.sv ----
// Status flags and start/stop condition control of the two-wire bus block.
// Assumes APB from the same clock; event inputs come from same-clock logic.
`timescale 1ns/1ns
`include "isc_map.svh"
module isc_top #(
  parameter int STEP_CYC = `ISC_STEP_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              en_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              transmit_empty_flag_i,
  input  wire logic              receive_full_flag_i,
  input  wire logic              second_addr_hit_i,
  input  wire logic              arb_lost_i,
  input  wire logic              frame_active_i,
  input  wire logic              iface_event_i,
  input  wire isc_pkg::isc_byte_t rx_byte_i,
  output isc_pkg::isc_byte_t     tx_byte_o,
  output logic                   irq_o
);
  import isc_pkg::*;

  logic       rst_m_reg;   // Reset release, first stage.
  logic       rst_n;       // Reset release, used by all logic.
  logic       scl_s;       // Synchronised clock line.
  logic       start_det;   // Start condition seen on the bus.
  logic       stop_det;    // Stop condition seen on the bus.
  logic       wr_fire;     // APB write completes this cycle.
  logic       rd_fire;     // APB read completes this cycle.
  logic       setup;       // APB setup cycle awaiting an answer.
  logic [3:0] mode_reg;    // Master, transmit, bus format, second format.
  isc_byte_t  mask_reg;    // Interrupt mask, same layout as the flags.
  isc_byte_t  flags_reg;   // Sticky status flags.
  isc_byte_t  flags_next;  // Next value of the flags.
  isc_byte_t  arm_reg;     // Flags read as one since last set.
  isc_byte_t  set_vec;     // Hardware set events.
  isc_byte_t  clr_vec;     // Clear events of all kinds.
  isc_byte_t  sw_clr;      // Armed zero written by software.
  logic       xfer_reg;    // Previous empty-or-full level.
  logic       xfer_rise;   // Empty or full flag just became one.
  logic       data_touch;  // Data access that clears arbitration loss.
  logic       line_busy_reg; // Bus held between a start and a stop.
  logic       own_hold_reg;  // This end holds the clock line after a start.
  logic       req_start;   // Software asks for a start.
  logic       req_stop;    // Software asks for a stop.
  isc_cond_t  cond_reg;    // Condition generator step.
  logic [7:0] tmr_reg;     // Step timer.

  localparam logic [7:0] STEP_LD = 8'(STEP_CYC - 1);

  // The reset is asserted at once but released through two flops.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_m_reg <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_n     <= rst_m_reg;
    end
  end

  // Line synchronisers and condition detector.
  isc_line_mon u_mon (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .en_i        (en_i),
    .scl_i       (scl_i),
    .sda_i       (sda_i),
    .scl_s_o     (scl_s),
    .start_det_o (start_det),
    .stop_det_o  (stop_det)
  );

  // The slave answers one cycle after setup, so every access takes two cycles.
  assign setup   = psel_i & ~penable_i & ~pready_o;
  assign wr_fire = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_fire = psel_i & penable_i & pready_o & ~pwrite_i;

  // Ready, error and read data are registered in the setup cycle.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (en_i) begin
      pready_o  <= setup;
      pslverr_o <= 1'b0;
      if (setup) begin
        prdata_o <= 32'h0000_0000;
        unique case (paddr_i)
          `ISC_OFS_CTRL: begin
            // The prohibit bit always reads one.
            prdata_o[`ISC_CTL_PROHIBIT] <= 1'b1;
            prdata_o[`ISC_CTL_BUSY]     <= line_busy_reg;
          end
          `ISC_OFS_MODE:  prdata_o[3:0] <= mode_reg;
          `ISC_OFS_FLAGS: prdata_o[7:0] <= flags_reg;
          `ISC_OFS_MASK:  prdata_o[7:0] <= mask_reg;
          `ISC_OFS_DATA:  prdata_o[7:0] <= pwrite_i ? tx_byte_o : rx_byte_i;
          // Unmapped addresses answer with an error and zero data.
          default:        pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // Mode, mask and transmit byte are plain storage.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg  <= `ISC_MODE_RST;
      mask_reg  <= `ISC_MASK_RST;
      tx_byte_o <= 8'h00;
    end else if (en_i && wr_fire) begin
      if (paddr_i == `ISC_OFS_MODE) begin
        mode_reg <= pwdata_i[3:0];
      end
      if (paddr_i == `ISC_OFS_MASK) begin
        mask_reg <= pwdata_i[7:0] & `ISC_FLG_IMPL;
      end
      if (paddr_i == `ISC_OFS_DATA) begin
        tx_byte_o <= pwdata_i[7:0];
      end
    end
  end

  // Rising edge of empty-or-full; same-clock inputs need no synchroniser.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xfer_reg <= 1'b0;
    end else if (en_i) begin
      xfer_reg <= transmit_empty_flag_i | receive_full_flag_i;
    end
  end
  assign xfer_rise = (transmit_empty_flag_i | receive_full_flag_i) & ~xfer_reg;

  // Set events; flags outside slave bus format are kept but meaningless.
  always_comb begin
    set_vec = 8'h00;
    // A stop inside a frame is an error stop.
    set_vec[`ISC_FLG_ERR_END] = stop_det & frame_active_i;
    // Every stop marks the normal-stop flag.
    set_vec[`ISC_FLG_STOP] = stop_det;
    // Slave mode needs a second-address match, other modes do not.
    set_vec[`ISC_FLG_CONT] = xfer_rise &
      (mode_reg[`ISC_MOD_MASTER] | flags_reg[`ISC_FLG_ADDR2]);
    // Second address received in slave receive outside the second format.
    set_vec[`ISC_FLG_ADDR2] = second_addr_hit_i & ~mode_reg[`ISC_MOD_MASTER] &
      ~mode_reg[`ISC_MOD_XMIT] & ~mode_reg[`ISC_MOD_ADDR2FMT];
    // Only a master can lose arbitration.
    set_vec[`ISC_FLG_ARB]   = arb_lost_i & mode_reg[`ISC_MOD_MASTER];
    set_vec[`ISC_FLG_IFACE] = iface_event_i;
  end

  // Data access in the right direction clears arbitration loss.
  assign data_touch = (paddr_i == `ISC_OFS_DATA) &
    ((wr_fire & mode_reg[`ISC_MOD_XMIT]) | (rd_fire & ~mode_reg[`ISC_MOD_XMIT]));

  // A zero clears a flag only if it was read as one first.
  assign sw_clr = (wr_fire && paddr_i == `ISC_OFS_FLAGS) ?
    (~pwdata_i[7:0] & arm_reg & `ISC_FLG_IMPL) : 8'h00;

  // Clear events gathered per flag.
  always_comb begin
    clr_vec = sw_clr;
    // Clearing the irq flag also clears its dependants.
    if (sw_clr[`ISC_FLG_IFACE]) begin
      clr_vec[`ISC_FLG_ERR_END] = 1'b1;
      clr_vec[`ISC_FLG_STOP] = 1'b1;
      clr_vec[`ISC_FLG_CONT] = 1'b1;
    end
    // Any start on the bus clears the second-address flag.
    clr_vec[`ISC_FLG_ADDR2] = sw_clr[`ISC_FLG_ADDR2] | start_det;
    clr_vec[`ISC_FLG_ARB]   = sw_clr[`ISC_FLG_ARB] | data_touch;
  end

  // The set wins over every clear, so no event is lost.
  assign flags_next = ((flags_reg & ~clr_vec) | set_vec) & `ISC_FLG_IMPL;

  // Flags and their read marks.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= `ISC_FLG_RST;
      arm_reg   <= 8'h00;
    end else if (en_i) begin
      flags_reg <= flags_next;
      // Arm on what the read really returned; a new set disarms.
      if (rd_fire && paddr_i == `ISC_OFS_FLAGS) begin
        arm_reg <= prdata_o[7:0] & ~set_vec & flags_next;
      end else begin
        arm_reg <= arm_reg & ~set_vec & flags_next;
      end
    end
  end

  // One level interrupt from any unmasked flag; a mask write counts at once.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else if (en_i) begin
      irq_o <= |(flags_next & ((wr_fire && paddr_i == `ISC_OFS_MASK) ? pwdata_i[7:0] : mask_reg));
    end
  end

  // Bus busy follows the conditions seen on the lines.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_busy_reg <= 1'b0;
    end else if (en_i) begin
      if (start_det) begin
        line_busy_reg <= 1'b1;
      end else if (stop_det) begin
        line_busy_reg <= 1'b0;
      end
    end
  end

  // Condition requests; a one in the prohibit bit suppresses both.
  assign req_start = wr_fire & (paddr_i == `ISC_OFS_CTRL) & mode_reg[`ISC_MOD_MASTER] &
    ~pwdata_i[`ISC_CTL_PROHIBIT] & pwdata_i[`ISC_CTL_BUSY];
  assign req_stop  = wr_fire & (paddr_i == `ISC_OFS_CTRL) & mode_reg[`ISC_MOD_MASTER] &
    ~pwdata_i[`ISC_CTL_PROHIBIT] & ~pwdata_i[`ISC_CTL_BUSY];

  // Condition generator; requests while a sequence runs are dropped,
  // since queueing them would let software race its own stop.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cond_reg     <= ISC_IDLE;
      tmr_reg      <= 8'h00;
      scl_oe_o     <= 1'b0;
      sda_oe_o     <= 1'b0;
      own_hold_reg <= 1'b0;
    end else if (en_i) begin
      if (arb_lost_i) begin
        // Losing arbitration releases both lines at once.
        cond_reg     <= ISC_IDLE;
        scl_oe_o     <= 1'b0;
        sda_oe_o     <= 1'b0;
        own_hold_reg <= 1'b0;
      end else if (cond_reg == ISC_IDLE) begin
        tmr_reg <= STEP_LD;
        if (req_start && own_hold_reg) begin
          // Mid-transfer start becomes a repeated start.
          cond_reg <= ISC_RS_SDA_UP;
          sda_oe_o <= 1'b0;
        end else if (req_start && !line_busy_reg) begin
          // Data falls while the clock line is high.
          cond_reg <= ISC_ST_SDA_DN;
          sda_oe_o <= 1'b1;
        end else if (req_stop && own_hold_reg) begin
          // Data held low before the clock is released.
          cond_reg <= ISC_SP_SDA_DN;
          sda_oe_o <= 1'b1;
        end
      end else if (tmr_reg != 8'h00) begin
        tmr_reg <= tmr_reg - 8'h01;
      end else if (cond_reg != ISC_RS_SCL_UP || scl_s) begin
        // Each step lasts its full time; a stretched clock delays restart.
        tmr_reg <= STEP_LD;
        unique case (cond_reg)
          ISC_RS_SDA_UP: begin
            cond_reg <= ISC_RS_SCL_UP;
            scl_oe_o <= 1'b0;
          end
          ISC_RS_SCL_UP: begin
            cond_reg <= ISC_ST_SDA_DN;
            sda_oe_o <= 1'b1;
          end
          ISC_ST_SDA_DN: begin
            cond_reg <= ISC_ST_SCL_DN;
            scl_oe_o <= 1'b1;
          end
          ISC_ST_SCL_DN: begin
            cond_reg     <= ISC_IDLE;
            own_hold_reg <= 1'b1;
          end
          ISC_SP_SDA_DN: begin
            cond_reg <= ISC_SP_SCL_UP;
            scl_oe_o <= 1'b0;
          end
          ISC_SP_SCL_UP: begin
            cond_reg <= ISC_SP_SDA_UP;
            sda_oe_o <= 1'b0;
          end
          ISC_SP_SDA_UP: begin
            cond_reg     <= ISC_IDLE;
            own_hold_reg <= 1'b0;
          end
          ISC_IDLE: cond_reg <= ISC_IDLE;
        endcase
      end
    end
  end

  // Open-drain lines only ever pull low.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (en_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // Checks run on enabled cycles only.
  default clocking cb @(posedge clk_i iff en_i);
  endclocking
  default disable iff (!rst_n);

  chk_prohibit_read: assert property (
    (setup && !pwrite_i && paddr_i == `ISC_OFS_CTRL) |=> prdata_o[`ISC_CTL_PROHIBIT] && pready_o)
    else $error("prohibit bit did not read one");
  chk_start_issue: assert property (
    (req_start && cond_reg == ISC_IDLE && !own_hold_reg && !line_busy_reg && !arb_lost_i)
    |=> sda_oe_o && !scl_oe_o ##[1:80] scl_oe_o)
    else $error("start not driven");
  chk_restart_issue: assert property (
    (req_start && cond_reg == ISC_IDLE && own_hold_reg && !arb_lost_i)
    |=> cond_reg == ISC_RS_SDA_UP && !sda_oe_o)
    else $error("repeated start not begun");
  chk_stop_issue: assert property (
    (req_stop && cond_reg == ISC_IDLE && own_hold_reg && !arb_lost_i)
    |=> (sda_oe_o throughout (scl_oe_o ##[1:80] !scl_oe_o)))
    else $error("stop not driven");
  chk_prohibit_block: assert property (
    (wr_fire && paddr_i == `ISC_OFS_CTRL && pwdata_i[`ISC_CTL_PROHIBIT] && cond_reg == ISC_IDLE
     && !arb_lost_i) |=> cond_reg == ISC_IDLE)
    else $error("condition issued with prohibit set");
  chk_errstop_set: assert property (
    (stop_det && frame_active_i) |=> flags_reg[`ISC_FLG_ERR_END] && flags_reg[`ISC_FLG_STOP])
    else $error("stop flags not set");
  chk_iface_clears: assert property (
    (sw_clr[`ISC_FLG_IFACE] && (set_vec & 8'hE2) == 8'h00)
    |=> (flags_reg & 8'hE2) == 8'h00)
    else $error("irq clear left dependants");
  chk_addr2_start: assert property (
    (start_det && !set_vec[`ISC_FLG_ADDR2]) |=> !flags_reg[`ISC_FLG_ADDR2])
    else $error("start did not clear second address flag");
  chk_arb_data: assert property (
    (data_touch && !set_vec[`ISC_FLG_ARB]) |=> !flags_reg[`ISC_FLG_ARB])
    else $error("data access did not clear arbitration flag");
  chk_unarmed_zero: assert property (
    (wr_fire && paddr_i == `ISC_OFS_FLAGS && !arm_reg[`ISC_FLG_ARB] && flags_reg[`ISC_FLG_ARB]
     && !data_touch) |=> flags_reg[`ISC_FLG_ARB])
    else $error("unread flag cleared");
  chk_irq_level: assert property (
    |(flags_reg & mask_reg) |-> irq_o)
    else $error("interrupt low with unmasked flag");

  cov_start: cover property (cond_reg == ISC_ST_SDA_DN ##1 cond_reg == ISC_ST_SCL_DN);
  cov_restart: cover property (cond_reg == ISC_RS_SCL_UP ##1 cond_reg == ISC_ST_SDA_DN);
  cov_stop: cover property (cond_reg == ISC_SP_SDA_UP ##1 cond_reg == ISC_IDLE);
  cov_arb_clear: cover property (flags_reg[`ISC_FLG_ARB] ##1 !flags_reg[`ISC_FLG_ARB]);
endmodule

// ---- isc_map.svh ----
// Register map, field positions and timing constants of the bus status block.
// Assumes a 32-bit APB slave and a 10 MHz system clock.
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

// Byte offsets of the registers on the APB.
`define ISC_OFS_CTRL    8'h00
`define ISC_OFS_MODE    8'h04
`define ISC_OFS_FLAGS   8'h08
`define ISC_OFS_MASK    8'h0C
`define ISC_OFS_DATA    8'h10

// Control register fields.
`define ISC_CTL_PROHIBIT 0
`define ISC_CTL_BUSY     7

// Mode register fields.
`define ISC_MOD_MASTER  0
`define ISC_MOD_XMIT    1
`define ISC_MOD_BUSFMT  2
`define ISC_MOD_ADDR2FMT 3

// Status flag positions.
`define ISC_FLG_ERR_END 7
`define ISC_FLG_STOP    6
`define ISC_FLG_CONT    5
`define ISC_FLG_ADDR2   4
`define ISC_FLG_ARB     3
`define ISC_FLG_IFACE   1

// Implemented flag bits and reset values.
`define ISC_FLG_IMPL    8'hFA
`define ISC_FLG_RST     8'h00
`define ISC_MODE_RST    4'h0
`define ISC_MASK_RST    8'h00

// Condition timing: each bus step is held at least this long.
`define ISC_CLK_MHZ     10
`define ISC_T_STEP_NS   5000
`define ISC_STEP_CYC    ((`ISC_T_STEP_NS * `ISC_CLK_MHZ + 999) / 1000)

`endif

// ---- isc_pkg.sv ----
// Types shared by the bus status block.
// Assumes the map header is included where constants are needed.
package isc_pkg;
  // One byte of register data.
  typedef logic [7:0] isc_byte_t;
  // Steps of start, repeated start and stop generation.
  typedef enum logic [2:0] {
    ISC_IDLE,
    ISC_RS_SDA_UP,
    ISC_RS_SCL_UP,
    ISC_ST_SDA_DN,
    ISC_ST_SCL_DN,
    ISC_SP_SDA_DN,
    ISC_SP_SCL_UP,
    ISC_SP_SDA_UP
  } isc_cond_t;
endpackage

// ---- isc_line_mon.sv ----
// Synchroniser and start/stop detector for the two bus lines.
// Assumes the lines are asynchronous to clk_i and are sampled many times per bit.
`timescale 1ns/1ns
module isc_line_mon (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_s_o,
  output logic      start_det_o,
  output logic      stop_det_o
);
  logic [1:0] meta_reg; // First stage, read only by the second stage.
  logic [1:0] sync_reg; // Second stage, safe to use.
  logic [1:0] prev_reg; // Previous synchronised sample for edge finding.

  // Two flops per line, then one more for edge detection.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else if (en_i) begin
      meta_reg <= {scl_i, sda_i};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // A data edge while the clock line stays high marks a condition.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_det_o <= 1'b0;
      stop_det_o  <= 1'b0;
    end else if (en_i) begin
      start_det_o <= sync_reg[1] & prev_reg[1] & prev_reg[0] & ~sync_reg[0];
      stop_det_o  <= sync_reg[1] & prev_reg[1] & ~prev_reg[0] & sync_reg[0];
    end
  end

  assign scl_s_o = sync_reg[1];
endmodule

// ---- isc_bus_peer.sv ----
// Far side of the two-wire bus: the pull-ups and one other node on the lines.
// Assumes the block pulls a line low while its enable is high.
`timescale 1ns/1ns
module isc_bus_peer (
  input  wire logic clk_i,
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic peer_scl_low = 1'b0; // The peer holds the clock line low.
  logic peer_sda_low = 1'b0; // The peer holds the data line low.

  // Wired-and with pull-ups, so a released line reads high and never shows stale data.
  assign scl_o = !(scl_oe_i || peer_scl_low);
  assign sda_o = !(sda_oe_i || peer_sda_low);

  // Half of an 800 ns link period at the 100 ns system clock.
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask

  // Start: data falls while the clock line is high, then the clock is taken low.
  task automatic send_start();
    @(posedge clk_i);
    peer_sda_low <= 1'b1;
    half();
    peer_scl_low <= 1'b1;
    half();
  endtask

  // Stop: data rises while the clock line is high; the clock then stands still.
  task automatic send_stop();
    @(posedge clk_i);
    peer_scl_low <= 1'b1;
    peer_sda_low <= 1'b1;
    half();
    peer_scl_low <= 1'b0;
    half();
    peer_sda_low <= 1'b0;
    half();
  endtask
endmodule

// ---- isc_top_tb.sv ----
// Self-checking bench for the bus status block, with a bus peer model.
// Assumes the register map header and a shortened condition step.
`timescale 1ns/1ns
`include "isc_map.svh"
module isc_top_tb;
  import isc_pkg::*;
  localparam int STEP = 4; // Short step keeps condition sequences brief.
  logic        clk_i = 1'b0;
  logic        nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, d;
  logic        scl_line, sda_line, scl_oe_o, sda_oe_o, te, rf, frame, irq_o;
  logic [2:0]  ev;        // Event pulses: iface event, second address, arbitration.
  logic        en = 1'b1, scl_do, sda_do; // Clock enable and the line data outputs.
  isc_byte_t   rx_byte_i, tx_byte_o;
  int          fail_count, comparisons, cycles;
  int          seed = 32'hb302;

  isc_top #(.STEP_CYC(STEP)) u_isc_top (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .scl_i(scl_line), .scl_o(scl_do), .scl_oe_o(scl_oe_o), .sda_i(sda_line), .sda_o(sda_do),
    .sda_oe_o(sda_oe_o), .transmit_empty_flag_i(te), .receive_full_flag_i(rf),
    .second_addr_hit_i(ev[1]), .arb_lost_i(ev[0]), .frame_active_i(frame),
    .iface_event_i(ev[2]), .rx_byte_i(rx_byte_i), .tx_byte_o(tx_byte_o), .irq_o(irq_o));
  isc_bus_peer u_isc_bus_peer (.clk_i(clk_i), .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
    .scl_o(scl_line), .sda_o(sda_line));

  always #50 clk_i = !clk_i;

  // A hang is cut short well after the whole sequence should be over.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected word of a byte register: the upper bits read zero.
  function automatic logic [31:0] low_byte(input logic [31:0] w);
    return {24'h000000, w[7:0]};
  endfunction

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(negedge clk_i); while (pready_o !== 1'b1);
    @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Reads the flag register and compares it with what the events predict.
  task automatic flags(input logic [7:0] exp);
    apb(1'b0, `ISC_OFS_FLAGS, 32'h0);
    check(rd, 32'(exp));
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask

  // Bounded wait for one of the pull-down enables to reach a level.
  task automatic wait_oe(input logic on_sda, input logic v);
    int n;
    n = 0;
    while ((on_sda ? sda_oe_o : scl_oe_o) !== v && n < 300) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, te, rf, frame, ev} = '0;
    {paddr_i, pwdata_i, rx_byte_i} = '0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    flags(8'h00);
    apb(1'b0, `ISC_OFS_CTRL, 32'h0);
    check(32'(rd[0]), 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // Master transmit: interrupt mask, armed clear and data-access clear.
    apb(1'b1, `ISC_OFS_MODE, 32'h3);
    apb(1'b1, `ISC_OFS_MASK, 32'h8);
    pulse(3'b001);
    check(32'(irq_o), 32'h1);
    apb(1'b1, `ISC_OFS_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    apb(1'b1, `ISC_OFS_FLAGS, 32'h0);
    flags(8'h08);
    apb(1'b1, `ISC_OFS_FLAGS, 32'h0);
    flags(8'h00);
    te <= 1'b1;
    flags(8'h20);
    te <= 1'b0;
    pulse(3'b001);
    apb(1'b1, `ISC_OFS_DATA, 32'h5A);
    flags(8'h20);
    // Random data traffic in both directions.
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      apb(1'b1, `ISC_OFS_DATA, d);
      rx_byte_i <= d[15:8];
      // The write lands at the edge that ends the transfer; look once it has settled.
      @(negedge clk_i);
      check(32'(tx_byte_o), low_byte(d));
      apb(1'b0, `ISC_OFS_DATA, 32'h0);
      check(rd, low_byte(d >> 8));
    end
    // Clock enable low freezes all state but the reset release, so an event in that time is lost.
    en <= 1'b0;
    pulse(3'b100);
    en <= 1'b1;
    flags(8'h20);
    // Slave receive: the continuous flag needs a second-address match first.
    apb(1'b1, `ISC_OFS_FLAGS, 32'h0);
    apb(1'b1, `ISC_OFS_MODE, 32'h0);
    rf <= 1'b1;
    flags(8'h00);
    rf <= 1'b0;
    pulse(3'b010);
    rf <= 1'b1;
    flags(8'h30);
    rf <= 1'b0;
    u_isc_bus_peer.send_start();
    flags(8'h20);
    frame <= 1'b1;
    u_isc_bus_peer.send_stop();
    frame <= 1'b0;
    flags(8'hE0);
    pulse(3'b100);
    flags(8'hE2);
    apb(1'b1, `ISC_OFS_FLAGS, 32'hFD);
    flags(8'h00);
    // Master conditions on the lines.
    apb(1'b1, `ISC_OFS_MODE, 32'h3);
    apb(1'b1, `ISC_OFS_CTRL, 32'h81);
    repeat (10) @(posedge clk_i);
    check(32'(sda_oe_o), 32'h0);
    apb(1'b1, `ISC_OFS_CTRL, 32'h80);
    wait_oe(1'b1, 1'b1);
    check(32'({sda_oe_o, scl_line}), 32'h3);
    check(32'({scl_do, sda_do}), 32'h0);
    wait_oe(1'b0, 1'b1);
    repeat (3 * STEP) @(posedge clk_i);
    apb(1'b1, `ISC_OFS_CTRL, 32'h80);
    wait_oe(1'b1, 1'b0);
    check(32'(sda_oe_o), 32'h0);
    wait_oe(1'b1, 1'b1);
    check(32'({sda_oe_o, scl_line}), 32'h3);
    repeat (3 * STEP) @(posedge clk_i);
    apb(1'b1, `ISC_OFS_CTRL, 32'h0);
    wait_oe(1'b1, 1'b0);
    check(32'({sda_oe_o, scl_line}), 32'h1);
    finish_test();
  end
endmodule
